// ---- adcgc_mac.sv ----
// Purpose: Shared types and constants, plus the gain and offset corrector of the converter
// Assumes: One clock mclk_i, asynchronous active-low reset rst_b_i
// Notes:   Corrector latency is fixed at MAC_LAT cycles whatever the calibration flag
`timescale 1ns/1ps
package adcgc_pkg;
    localparam int RAW_W      = 12;
    localparam int RES_W      = 14;
    localparam int GAIN_W     = 15;
    localparam int OFF_W      = 14;
    localparam int PROD_W     = RAW_W + GAIN_W;
    localparam int GAIN_FRAC  = 14;
    localparam int MAC_LAT    = 2;
    // Gain is unsigned 1.14, offset is signed in quarter-LSB units
    localparam logic [GAIN_W-1:0] GAIN_ONE    = 15'h4000;
    localparam logic [OFF_W-1:0]  OFF_ZERO    = 14'h0000;
    localparam logic [RES_W-1:0]  HALF_LSB    = 14'h0002;
    localparam logic [RES_W-1:0]  RES_MAX     = 14'h3fff;
    localparam int                UNCAL_SHIFT = 2;
    // Sequencer timing at 250 MHz
    localparam int                CLK_PS      = 4000;
    localparam int                SAMPLE_CLKS = 2;
    localparam int                SYNC_CLKS   = 2;
    localparam int                PHASES      = 12;
    localparam logic [3:0]        LAST_PHASE  = 4'hb;
    localparam logic [1:0]        SAMPLE_LAST = 2'(SAMPLE_CLKS - 1);
    localparam logic [1:0]        SETTLE_LAST = 2'(SYNC_CLKS);
    localparam logic [1:0]        DIG_NONE    = 2'h0;
    localparam logic [1:0]        DIG_ONE     = 2'h1;
    localparam logic [1:0]        DIG_TWO     = 2'h2;

    typedef struct packed {
        logic             cal;
        logic [RAW_W-1:0] raw;
    } adcgc_conv_s;

    typedef struct packed {
        logic             cal;
        logic [RES_W-1:0] data;
    } adcgc_result_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_PHASE
    } adcgc_state_e;
endpackage

module adcgc_mac
    import adcgc_pkg::*;
(
    input  wire logic               mclk_i,
    input  wire logic               rst_b_i,
    input  wire logic               in_valid_i,
    input  wire adcgc_conv_s        in_conv_i,
    input  wire logic [GAIN_W-1:0]  gain_i,
    input  wire logic [OFF_W-1:0]   offset_i,
    output logic                    out_valid_o,
    output adcgc_result_s           out_result_o
);
    logic                 st1_valid;
    logic                 st1_cal;
    logic [RAW_W-1:0]     st1_raw;
    logic [PROD_W-1:0]    st1_prod;
    logic signed [OFF_W-1:0] st1_off;

    wire logic [PROD_W-1:0] prod     = PROD_W'(in_conv_i.raw) * PROD_W'(gain_i);
    // Scale 1.14 gain times 12-bit raw down to the 14-bit result grid
    wire logic [PROD_W-1:0] prod_res = st1_prod >> (GAIN_FRAC - UNCAL_SHIFT);
    wire logic [PROD_W-1:0] uncal    = PROD_W'(st1_raw) << UNCAL_SHIFT;
    wire logic [PROD_W-1:0] scaled   = st1_cal ? prod_res : uncal;
    wire logic signed [PROD_W+1:0] off_ext = st1_cal ? (PROD_W+2)'(st1_off) : '0;
    wire logic signed [PROD_W+1:0] sum = $signed({2'b00, scaled}) + off_ext
                                         + $signed((PROD_W+2)'(HALF_LSB));
    // Clamp instead of wrapping so a large offset cannot fold a result to the far end
    wire logic sat_lo = sum < 0;
    wire logic sat_hi = sum > $signed((PROD_W+2)'(RES_MAX));
    wire logic [RES_W-1:0] clamped = sat_lo ? '0 : sat_hi ? RES_MAX : sum[RES_W-1:0];

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st1_valid    <= 1'b0;
            st1_cal      <= 1'b0;
            st1_raw      <= '0;
            st1_prod     <= '0;
            st1_off      <= '0;
            out_valid_o  <= 1'b0;
            out_result_o <= '0;
        end
        else
        begin
            st1_valid         <= in_valid_i;
            st1_cal           <= in_conv_i.cal;
            st1_raw           <= in_conv_i.raw;
            st1_prod          <= prod;
            st1_off           <= offset_i;
            out_valid_o       <= st1_valid;
            out_result_o.cal  <= st1_cal;
            out_result_o.data <= clamped;
        end
    end
endmodule

// ---- adcgc_top.sv ----
// Purpose: Conversion sequencer and result corrector of a redundant-digit converter
// Assumes: Comparator answers arrive asynchronously from the analogue engine
// Notes:   One conversion at a time; commands are refused while busy
// Functional notes
// - Calibration flag set routes result through corrector
// - Calibrated output is gain times raw plus offset
// - Gain one, offset zero leaves result unchanged
// - Raw 12 bits, gain 15, offset 14 bits
// - Products are 27 bits wide, output is 14 bits wide
// - Add two to every 14-bit result
// - Uncalibrated: raw times four plus two
// - Bits resolved MSB first, residue doubled each step
// - Input connected only during two-cycle sampling
// - Compare at 25% and 75%, combine two-bit digits
// - Ground channel reads 2032 after correction
`timescale 1ns/1ps
module adcgc_top
    import adcgc_pkg::*;
(
    input  wire logic               mclk_i,
    input  wire logic               rst_b_i,
    input  wire logic               cmd_valid_i,
    input  wire logic               cmd_cal_i,
    output logic                    cmd_ready_o,
    input  wire logic               gain_load_i,
    input  wire logic [GAIN_W-1:0]  gain_coeff_i,
    input  wire logic               offset_load_i,
    input  wire logic [OFF_W-1:0]   offset_coeff_i,
    output logic [GAIN_W-1:0]       gain_correction_coeff_o,
    output logic [OFF_W-1:0]        offset_correction_coeff_o,
    input  wire logic               cmp_quarter_i,
    input  wire logic               cmp_three_quarter_i,
    output logic                    sample_o,
    output logic                    step_o,
    output logic [1:0]              ref_sel_o,
    output logic                    busy_o,
    output logic                    raw_valid_o,
    output adcgc_conv_s             raw_o,
    output logic                    result_valid_o,
    output adcgc_result_s           result_o
);
    adcgc_state_e         state;
    adcgc_state_e         next_state;
    logic [1:0]           cnt;
    logic [3:0]           phase;
    logic [RAW_W:0]       acc;
    logic                 cal_flag;
    wire logic [1:0]      cmp_pins = {cmp_three_quarter_i, cmp_quarter_i};
    wire logic [1:0]      cmp_sync;

    // Analogue comparators are asynchronous to mclk_i; one two-stage chain per pin
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sync
            logic [1:0] pipe;
            always_ff @(posedge mclk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    pipe <= 2'b00;
                else
                    pipe <= {pipe[0], cmp_pins[gi]};
            end
            // Only the second stage is read; the first may still be settling
            assign cmp_sync[gi] = pipe[1];
        end
    endgenerate

    wire logic cmp_lo = cmp_sync[0];
    wire logic cmp_hi = cmp_sync[1];
    // Above 75% gives two, between the points one, below 25% zero
    wire logic [1:0] digit = cmp_hi ? DIG_TWO : (cmp_lo ? DIG_ONE : DIG_NONE);

    // No queue: a request while busy is dropped, so the source must wait for ready
    wire logic cmd_take    = cmd_valid_i && (state == ST_IDLE);
    wire logic sample_done = (state == ST_SAMPLE) && (cnt == SAMPLE_LAST);
    // Each phase waits for the engine to settle and the answer to cross the synchroniser
    wire logic decide      = (state == ST_PHASE) && (cnt == SETTLE_LAST);
    wire logic conv_done   = decide && (phase == LAST_PHASE);
    // Redundant digits weigh double; one shift folds the sum back to 12 bits
    wire logic [RAW_W:0] next_acc = {acc[RAW_W-1:0], 1'b0} + (RAW_W+1)'(digit);

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (cmd_take)
                    next_state = ST_SAMPLE;
            end
            ST_SAMPLE:
            begin
                if (sample_done)
                    next_state = ST_PHASE;
            end
            ST_PHASE:
            begin
                if (conv_done)
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state <= ST_IDLE;
            cnt   <= 2'h0;
            phase <= 4'h0;
        end
        else
        begin
            state <= next_state;
            if (cmd_take || sample_done || decide)
                cnt <= 2'h0;
            else if (state != ST_IDLE)
                cnt <= cnt + 2'h1;
            if (cmd_take)
                phase <= 4'h0;
            else if (decide)
                phase <= phase + 4'h1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            acc      <= '0;
            cal_flag <= 1'b0;
        end
        else
        begin
            if (cmd_take)
            begin
                acc      <= '0;
                cal_flag <= cmd_cal_i;
            end
            else if (decide)
                acc <= next_acc;
        end
    end

    // Engine strobes: double the residue, then subtract the selected reference
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            step_o      <= 1'b0;
            ref_sel_o   <= DIG_NONE;
            raw_valid_o <= 1'b0;
        end
        else
        begin
            step_o      <= decide;
            ref_sel_o   <= decide ? digit : DIG_NONE;
            raw_valid_o <= conv_done;
        end
    end

    // Raw word holds until the next conversion ends, so a late reader still sees it
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            raw_o <= '0;
        end
        else if (conv_done)
        begin
            raw_o.cal <= cal_flag;
            raw_o.raw <= next_acc[RAW_W:1];
        end
    end

    // Ideal defaults so an early calibrated conversion matches an uncalibrated one
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            gain_correction_coeff_o <= GAIN_ONE;
        end
        else if (gain_load_i)
        begin
            gain_correction_coeff_o <= gain_coeff_i;
        end
    end

    // Loads are not locked out while busy; the corrector uses what stands at raw_valid_o
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            offset_correction_coeff_o <= OFF_ZERO;
        end
        else if (offset_load_i)
        begin
            offset_correction_coeff_o <= offset_coeff_i;
        end
    end

    // Input switch closes only while sampling
    assign sample_o    = (state == ST_SAMPLE);
    assign cmd_ready_o = (state == ST_IDLE);
    assign busy_o      = (state != ST_IDLE);

    adcgc_mac u_mac
    (
        .mclk_i       (mclk_i),
        .rst_b_i      (rst_b_i),
        .in_valid_i   (raw_valid_o),
        .in_conv_i    (raw_o),
        .gain_i       (gain_correction_coeff_o),
        .offset_i     (offset_correction_coeff_o),
        .out_valid_o  (result_valid_o),
        .out_result_o (result_o)
    );
endmodule

// ---- adcgc_engine_model.sv ----
// Purpose: Behavioural analogue engine facing the conversion sequencer
// Assumes: Residue is an integer, full scale 65536
// Notes:   Engine settles on the falling edge, before the design samples it
`timescale 1ns/1ps
module adcgc_engine_model
(
    input  wire logic        mclk_i,
    input  wire logic        sample_i,
    input  wire logic        step_i,
    input  wire logic [1:0]  ref_sel_i,
    input  wire logic [15:0] vin_i,
    output logic             cmp_quarter_o,
    output logic             cmp_three_quarter_o
);
    int residue = 0;
    assign cmp_quarter_o       = residue > 16384;
    assign cmp_three_quarter_o = residue > 49152;
    always @(negedge mclk_i)
    begin
        if (sample_i)
            residue <= int'(vin_i);
        else if (step_i)
            residue <= 2 * residue - 32768 * int'(ref_sel_i);
    end
endmodule

// ---- adcgc_checker.sv ----
// Purpose: Port-level assertions on the converter back end
// Assumes: Single clock domain, reset active low
// Notes:   Bound to every adcgc_top instance
`timescale 1ns/1ps
module adcgc_checker
    import adcgc_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              rst_b_i,
    input  wire logic              cmd_valid_i,
    input  wire logic              cmd_ready_o,
    input  wire logic              gain_load_i,
    input  wire logic [GAIN_W-1:0] gain_coeff_i,
    input  wire logic              offset_load_i,
    input  wire logic [OFF_W-1:0]  offset_coeff_i,
    input  wire logic [GAIN_W-1:0] gain_correction_coeff_o,
    input  wire logic [OFF_W-1:0]  offset_correction_coeff_o,
    input  wire logic              sample_o,
    input  wire logic              step_o,
    input  wire logic [1:0]        ref_sel_o,
    input  wire logic              raw_valid_o,
    input  wire adcgc_conv_s       raw_o,
    input  wire logic              result_valid_o,
    input  wire adcgc_result_s     result_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    wire take = cmd_valid_i && cmd_ready_o;
    wire ideal = gain_correction_coeff_o == GAIN_ONE && offset_correction_coeff_o == OFF_ZERO;

    property p_lat; raw_valid_o |-> ##2 result_valid_o; endproperty
    a_lat: assert property (p_lat) else $error("result latency wrong");
    property p_conv; take |-> ##39 raw_valid_o; endproperty
    a_conv: assert property (p_conv) else $error("conversion length wrong");
    property p_samp; take |=> sample_o [*2] ##1 !sample_o; endproperty
    a_samp: assert property (p_samp) else $error("sampling not two cycles");
    property p_step; take |-> ##6 step_o ##3 step_o; endproperty
    a_step: assert property (p_step) else $error("phase steps misplaced");
    property p_dig; step_o ? ref_sel_o != 2'h3 : ref_sel_o == 2'h0; endproperty
    a_dig: assert property (p_dig) else $error("bad digit on reference select");
    property p_uncal;
        raw_valid_o && !raw_o.cal |-> ##2 result_o == {1'b0, $past(raw_o.raw, 2), 2'b10};
    endproperty
    a_uncal: assert property (p_uncal) else $error("uncalibrated format wrong");
    property p_ideal;
        raw_valid_o && raw_o.cal && ideal |-> ##2 result_o.data == {$past(raw_o.raw, 2), 2'b10};
    endproperty
    a_ideal: assert property (p_ideal) else $error("ideal coefficients changed result");
    property p_flag; raw_valid_o |-> ##2 result_o.cal == $past(raw_o.cal, 2); endproperty
    a_flag: assert property (p_flag) else $error("calibration flag lost");
    property p_gld; gain_load_i |=> gain_correction_coeff_o == $past(gain_coeff_i); endproperty
    a_gld: assert property (p_gld) else $error("gain not loaded");
    property p_old; offset_load_i |=> offset_correction_coeff_o == $past(offset_coeff_i); endproperty
    a_old: assert property (p_old) else $error("offset not loaded");
endmodule

bind adcgc_top adcgc_checker chk (.*);

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the converter back end
// Assumes: Engine model answers comparator pins
// Notes:   Inputs are picked so that the redundant digits fold back to exactly v[15:4]
`timescale 1ns/1ps
module tb_top
    import adcgc_pkg::*;
();
    logic          mclk_i = 1'b0, rst_b_i = 1'b0;
    logic          cmd_valid = 1'b0, cmd_cal = 1'b0, gain_load = 1'b0, off_load = 1'b0;
    logic [14:0]   gain_coeff = 15'h0000;
    logic [13:0]   off_coeff = 14'h0000;
    logic [15:0]   vin = 16'h0000;
    logic          ready, cmp_q, cmp_t, sample, step, busy, raw_valid, res_valid;
    logic [14:0]   gain_o;
    logic [13:0]   off_o;
    logic [1:0]    ref_sel;
    adcgc_conv_s   raw;
    adcgc_result_s res;
    int            err_count = 0, n_compared = 0;

    adcgc_top uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid),
        .cmd_cal_i(cmd_cal), .cmd_ready_o(ready), .gain_load_i(gain_load),
        .gain_coeff_i(gain_coeff), .offset_load_i(off_load), .offset_coeff_i(off_coeff),
        .gain_correction_coeff_o(gain_o), .offset_correction_coeff_o(off_o),
        .cmp_quarter_i(cmp_q), .cmp_three_quarter_i(cmp_t), .sample_o(sample),
        .step_o(step), .ref_sel_o(ref_sel), .busy_o(busy), .raw_valid_o(raw_valid),
        .raw_o(raw), .result_valid_o(res_valid), .result_o(res));
    adcgc_engine_model eng (.mclk_i(mclk_i), .sample_i(sample), .step_i(step),
        .ref_sel_i(ref_sel), .vin_i(vin), .cmp_quarter_o(cmp_q), .cmp_three_quarter_o(cmp_t));

    always #2 mclk_i = ~mclk_i;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Clamp mirrors saturation at both ends of the 14-bit range
    function automatic logic [13:0] ex(int r, int g, int o, bit c);
        int t;
        t = c ? ((r * g) >>> 12) + o + 2 : r * 4 + 2;
        return (t < 0) ? 14'h0000 : (t > 16383) ? 14'h3fff : 14'(t);
    endfunction

    task automatic run(input logic [15:0] v, input bit c, input int g, input int o);
        int n;
        @(posedge mclk_i);
        gain_load <= 1'b1;
        gain_coeff <= 15'(g);
        off_load <= 1'b1;
        off_coeff <= 14'(o);
        vin <= v;
        @(posedge mclk_i);
        gain_load <= 1'b0;
        off_load <= 1'b0;
        cmd_valid <= 1'b1;
        cmd_cal <= c;
        #1;
        check({1'b0, gain_o}, 16'(g));
        check({2'b00, off_o}, {2'b00, 14'(o)});
        @(posedge mclk_i);
        cmd_valid <= 1'b0;
        #1;
        check({15'h0000, busy}, 16'h0001);
        check({15'h0000, ready}, 16'h0000);
        n = 0;
        do
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end while (raw_valid !== 1'b1 && n < 60);
        check({3'b000, raw}, {3'b000, c, v[15:4]});
        repeat (2) @(posedge mclk_i);
        #1;
        check({res_valid, res}, {1'b1, c, ex(int'(v[15:4]), g, o, c)});
    endtask

    task automatic s_uncal;
        run(16'h0a35, 0, 'h2000, 10);
        run(16'hfffd, 0, 'h2000, 10);
    endtask
    task automatic s_ideal;
        run(16'h0a35, 1, 'h4000, 0);
    endtask
    task automatic s_cal;
        run(16'h0a35, 1, 'h2000, 10);
        run(16'h800d, 1, 'h4000, -66);
        check({4'h0, res.data[13:2]}, 16'h07f0);
    endtask
    task automatic s_sat;
        run(16'hfffd, 1, 'h7fff, 0);
        run(16'h0015, 1, 'h4000, -100);
    endtask

    initial
    begin
        #20000;
        err_count++;
        end_of_test();
    end

    initial
    begin
        repeat (20) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        #1;
        check({1'b0, gain_o}, {1'b0, GAIN_ONE});
        check({2'b00, off_o}, {2'b00, OFF_ZERO});
        check({15'h0000, ready}, 16'h0001);
        s_uncal();
        s_ideal();
        s_cal();
        s_sat();
        end_of_test();
    end
endmodule
